/* core/ubds_engine.sv */
/*
 Buffer descriptor status engine with AXI4-Lite register slave.
 Assumes a link front end that delivers one decoded token or packet
 per pkt_valid pulse and reads back one handshake per resp_valid.
*/
// Behaviour
// (R1) Firmware writes the descriptor status byte after all others.
// (R2) Ownership is dropped at completion unless keep or stall is set.
// (R3) Firmware leaves engine-owned descriptor memory alone.
// (R4) With ownership clear the other seven bits are firmware control.
// (R5) Keep-enable holds ownership and posts no status or completion.
// (R6) Firmware sets keep-enable only for the streaming parallel port.
// (R7) Address-increment-disable holds the buffer address per byte.
// (R8) Toggle sync compares packet parity against the expected toggle.
// (R9) Toggle mismatch drops data and flag yet still answers ACK.
// (R10) OUT outcome: match ACK done, mismatch ACK kept, error NAK kept.
// (R11) Buffer stall answers any token but SETUP using the descriptor with STALL.
// (R12) Each STALL sets the endpoint stalled flag and a stall interrupt.
// (R13) Stall keeps ownership; SETUP clears stall and returns ownership.
// (R14) Status bits 1:0 hold the top two bits of the byte count.
`timescale 1ns/1ps
`default_nettype none
`include "ubds_map.svh"

module ubds_engine #(
    parameter int CNT_W = 10
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pkt_valid,
    input wire ubds_pkg::ubds_pkt_t pkt,
    input wire logic byte_strobe,
    output logic resp_valid,
    output ubds_pkg::ubds_resp_t resp,
    output logic [CNT_W-1:0] buf_addr,
    output logic fifo_push,
    output logic irq
);
    import ubds_pkg::*;

    default clocking cb_mclk @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // Only a ten-bit buffer address fits the 22-bit zero pad of the base read-back
    if (CNT_W != 10) begin : g_cnt_w_check
        $error("ubds_engine: CNT_W must be 10");
    end

    // ============================================================
    // Registers
    logic [7:0] bd_stat;
    logic [7:0] bd_cnt;
    logic [7:0] ep_ctl;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [CNT_W-1:0] buf_base;
    logic [7:0] fifo_cnt;
    ubds_state_t state;
    ubds_pkt_t cur;

    // ============================================================
    // Descriptor decode
    logic own, tsen;
    logic keep_enable_bit, address_increment_disable;
    logic expected_toggle_bit, buffer_stall_bit;
    assign own = bd_stat[`UBDS_OWN_BIT];
    assign expected_toggle_bit = bd_stat[`UBDS_TOGGLE_BIT];
    assign keep_enable_bit = bd_stat[`UBDS_KEEP_BIT];
    assign address_increment_disable = bd_stat[`UBDS_INC_BIT];
    assign tsen = bd_stat[`UBDS_TSEN_BIT];
    assign buffer_stall_bit = bd_stat[`UBDS_STALL_BIT];

    // Evaluation results, valid in UBDS_ST_EVAL
    logic ev_stall, ev_nak, ev_mis, ev_done, ev_setup_clr;
    always_comb begin
        ev_setup_clr = own && buffer_stall_bit &&
            cur.tok == UBDS_TOK_SETUP; // R13
        ev_stall = own && buffer_stall_bit && !ev_setup_clr; // R11
        ev_nak = !own || (cur.err && !ev_stall && !ev_setup_clr); // R10
        ev_mis = !ev_nak && !ev_stall && !ev_setup_clr &&
            cur.tok == UBDS_TOK_OUT && tsen &&
            (cur.toggle != expected_toggle_bit); // R8
        ev_done = !ev_nak && !ev_stall && !ev_mis && !ev_setup_clr;
    end

    // ============================================================
    // AXI4-Lite write channel
    logic aw_hold, w_hold;
    logic [7:0] aw_a;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic wr_go;
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign wr_go = aw_hold && w_hold && !s_axi_bvalid;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_a <= 8'h00;
            w_d <= 32'h0000_0000;
            w_s <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_a <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_d <= s_axi_wdata;
                w_s <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok(aw_a) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = a <= `UBDS_FIFO_OFS && a[1:0] == 2'h0;
    endfunction

    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = wr_go && aw_a == ofs && w_s[0];
    endfunction

    // ============================================================
    // Descriptor status and count
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            bd_stat <= `UBDS_STAT_RST;
            bd_cnt <= `UBDS_CNT_RST;
        end else if (state == UBDS_ST_EVAL && own) begin
            if (ev_setup_clr) begin
                bd_stat[`UBDS_OWN_BIT] <= 1'b0; // R13
                bd_stat[`UBDS_STALL_BIT] <= 1'b0; // R13
            end else if (ev_done && !keep_enable_bit) begin
                bd_stat[`UBDS_OWN_BIT] <= 1'b0; // R2
                if (cur.tok != UBDS_TOK_IN) begin
                    bd_stat[1:0] <= cur.len[9:8]; // R14
                    bd_cnt <= cur.len[7:0]; // R14
                end
            end
        end else if (!own) begin
            // CPU owns the descriptor; bits act as controls
            if (wr_hit(`UBDS_STAT_OFS)) bd_stat <= w_d[7:0]; // R4
            if (wr_hit(`UBDS_CNT_OFS)) bd_cnt <= w_d[7:0];
        end
    end

    // ============================================================
    // Link transaction sequencing
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state <= UBDS_ST_IDLE;
            cur <= '0;
            resp_valid <= 1'b0;
            resp <= '0;
        end else begin
            resp_valid <= 1'b0;
            case (state)
                UBDS_ST_IDLE: begin
                    if (pkt_valid) begin
                        cur <= pkt;
                        state <= UBDS_ST_EVAL;
                    end
                end
                UBDS_ST_EVAL: begin
                    resp_valid <= 1'b1;
                    resp.wr_ram <= ev_done && cur.tok != UBDS_TOK_IN; // R9
                    if (ev_stall) resp.hs <= UBDS_HS_STALL; // R11
                    else if (ev_nak) resp.hs <= UBDS_HS_NAK; // R10
                    else resp.hs <= UBDS_HS_ACK; // R9
                    state <= UBDS_ST_RESP;
                end
                UBDS_ST_RESP: state <= UBDS_ST_IDLE;
                default: state <= UBDS_ST_IDLE;
            endcase
        end
    end

    // ============================================================
    // Buffer address walker
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            buf_base <= `UBDS_ADDR_RST;
            buf_addr <= `UBDS_ADDR_RST;
        end else begin
            if (wr_hit(`UBDS_ADDR_OFS) && !own) begin
                buf_base <= w_d[CNT_W-1:0];
                buf_addr <= w_d[CNT_W-1:0];
            end else if (!own) begin
                buf_addr <= buf_base;
            end else if (byte_strobe && !address_increment_disable) begin
                buf_addr <= buf_addr + 1'b1; // R7
            end
        end
    end

    // ============================================================
    // Status FIFO push, endpoint control and interrupts
    logic ev_trn, ev_stl;
    assign ev_trn = state == UBDS_ST_EVAL && ev_done &&
        !keep_enable_bit; // R5
    assign ev_stl = state == UBDS_ST_EVAL && ev_stall; // R12

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            fifo_push <= 1'b0;
            fifo_cnt <= 8'h00;
        end else begin
            fifo_push <= ev_trn; // R5
            if (ev_trn) fifo_cnt <= fifo_cnt + 8'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ep_ctl <= 8'h00;
        end else if (ev_stl) begin
            ep_ctl[`UBDS_EP_STALLED] <= 1'b1; // R12
        end else if (wr_hit(`UBDS_EPCTL_OFS)) begin
            ep_ctl <= w_d[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
        end else begin
            if (wr_hit(`UBDS_IRQ_STAT_OFS)) irq_stat <= irq_stat & ~w_d[1:0];
            if (ev_trn) irq_stat[`UBDS_IRQ_TRN] <= 1'b1; // R5
            if (ev_stl) irq_stat[`UBDS_IRQ_STALL] <= 1'b1; // R12
            if (wr_hit(`UBDS_IRQ_MASK_OFS)) irq_mask <= w_d[1:0];
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ============================================================
    // AXI4-Lite read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= addr_ok(s_axi_araddr) ? 2'h0 : 2'h2;
            if (s_axi_araddr == `UBDS_STAT_OFS)
                s_axi_rdata <= {24'h0, bd_stat};
            else if (s_axi_araddr == `UBDS_CNT_OFS)
                s_axi_rdata <= {24'h0, bd_cnt};
            else if (s_axi_araddr == `UBDS_EPCTL_OFS)
                s_axi_rdata <= {24'h0, ep_ctl};
            else if (s_axi_araddr == `UBDS_IRQ_STAT_OFS)
                s_axi_rdata <= {30'h0, irq_stat};
            else if (s_axi_araddr == `UBDS_IRQ_MASK_OFS)
                s_axi_rdata <= {30'h0, irq_mask};
            else if (s_axi_araddr == `UBDS_ADDR_OFS)
                s_axi_rdata <= {22'h0, buf_base};
            else if (s_axi_araddr == `UBDS_FIFO_OFS)
                s_axi_rdata <= {24'h0, fifo_cnt};
            else
                s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ============================================================
    // Checks
    sequence s_eval_stall;
        state == UBDS_ST_EVAL && ev_stall;
    endsequence

    sequence s_eval_good_out;
        state == UBDS_ST_EVAL && own && !buffer_stall_bit && !cur.err &&
            cur.tok == UBDS_TOK_OUT && !keep_enable_bit &&
            (!tsen || cur.toggle == expected_toggle_bit);
    endsequence

    a_stall_answer: assert property (s_eval_stall |=> // R11
        resp_valid && resp.hs == UBDS_HS_STALL)
        else $error("stall token not answered with STALL");
    a_stall_flag: assert property (s_eval_stall |=> // R12
        ep_ctl[`UBDS_EP_STALLED] && irq_stat[`UBDS_IRQ_STALL])
        else $error("stall did not set flags");
    a_own_release: assert property ( // R2
        state == UBDS_ST_EVAL && ev_done && !keep_enable_bit |=> !own)
        else $error("ownership not released");
    a_keep_hold: assert property ( // R5
        state == UBDS_ST_EVAL && own && keep_enable_bit &&
            !buffer_stall_bit |=> own && !fifo_push)
        else $error("keep enable lost ownership");
    a_mismatch_ack: assert property ( // R9
        state == UBDS_ST_EVAL && ev_mis |=> resp.hs == UBDS_HS_ACK
            && !resp.wr_ram && own)
        else $error("mismatch handled wrongly");
    a_err_nak: assert property ( // R10
        state == UBDS_ST_EVAL && own && !buffer_stall_bit && cur.err
            |=> resp.hs == UBDS_HS_NAK && own)
        else $error("errored packet not NAKed");
    a_setup_clear: assert property ( // R13
        state == UBDS_ST_EVAL && ev_setup_clr
            |=> !own && !buffer_stall_bit)
        else $error("setup did not clear stall");
    a_addr_hold: assert property ( // R7
        own && address_increment_disable && byte_strobe
            |=> $stable(buf_addr))
        else $error("address moved with increment disabled");
    a_count_upper: assert property ( // R14
        state == UBDS_ST_EVAL && ev_done && !keep_enable_bit &&
            cur.tok == UBDS_TOK_OUT |=> bd_stat[1:0] == $past(cur.len[9:8]))
        else $error("upper count bits wrong");
    a_good_out: assert property (s_eval_good_out |=> // R10
        resp.hs == UBDS_HS_ACK && resp.wr_ram && !own && fifo_push)
        else $error("accepted packet not completed");
    a_idle_nak: assert property ( // R4
        state == UBDS_ST_EVAL && !own |=> resp_valid
            && resp.hs == UBDS_HS_NAK && !resp.wr_ram)
        else $error("unowned descriptor not NAKed");
    a_push_flag: assert property (fifo_push |-> // R5
        irq_stat[`UBDS_IRQ_TRN])
        else $error("status entry without completion flag");

endmodule // ubds_engine
`default_nettype wire

/* core/ubds_map.svh */
/*
 Register offsets, field positions and reset values of the
 descriptor status engine. Assumes nothing; definitions only.
*/
`ifndef UBDS_MAP_SVH
`define UBDS_MAP_SVH

// ============================================================
// Register byte offsets
`define UBDS_STAT_OFS 8'h00
`define UBDS_CNT_OFS 8'h04
`define UBDS_EPCTL_OFS 8'h08
`define UBDS_IRQ_STAT_OFS 8'h0C
`define UBDS_IRQ_MASK_OFS 8'h10
`define UBDS_ADDR_OFS 8'h14
`define UBDS_FIFO_OFS 8'h18

// ============================================================
// Descriptor status fields
`define UBDS_OWN_BIT 7
`define UBDS_TOGGLE_BIT 6
`define UBDS_KEEP_BIT 5
`define UBDS_INC_BIT 4
`define UBDS_TSEN_BIT 3
`define UBDS_STALL_BIT 2

// ============================================================
// Interrupt bits, endpoint control bits
`define UBDS_IRQ_TRN 0
`define UBDS_IRQ_STALL 1
`define UBDS_EP_STALLED 0

// ============================================================
// Reset values
`define UBDS_STAT_RST 8'h00
`define UBDS_CNT_RST 8'h00
`define UBDS_ADDR_RST 10'h000

`endif

/* core/ubds_pkg.sv */
/*
 Types of the descriptor status engine.
 Assumes ubds_map.svh is on the include path.
*/
`default_nettype none
package ubds_pkg;

    typedef enum logic [1:0] {
        UBDS_TOK_OUT = 2'h0,
        UBDS_TOK_IN = 2'h1,
        UBDS_TOK_SETUP = 2'h2
    } ubds_tok_t;

    typedef enum logic [1:0] {
        UBDS_HS_ACK = 2'h0,
        UBDS_HS_NAK = 2'h1,
        UBDS_HS_STALL = 2'h2
    } ubds_hs_t;

    // Token or packet from the link side
    typedef struct packed {
        ubds_tok_t tok;
        logic toggle;
        logic err;
        logic [9:0] len;
    } ubds_pkt_t;

    // Handshake answer to the link side
    typedef struct packed {
        ubds_hs_t hs;
        logic wr_ram;
    } ubds_resp_t;

    typedef enum logic [2:0] {
        UBDS_ST_IDLE = 3'b001,
        UBDS_ST_EVAL = 3'b010,
        UBDS_ST_RESP = 3'b100
    } ubds_state_t;

endpackage
`default_nettype wire

/* test/ubds_host_model.sv */
/*
 Link-side host model: offers tokens and packets, collects handshakes.
 Assumes the engine's pulse-per-packet link contract.
*/
`timescale 1ns/1ps
`default_nettype none
module ubds_host_model (
    input wire logic mclk,
    input wire logic resp_valid,
    input wire ubds_pkg::ubds_resp_t resp,
    output var logic pkt_valid,
    output var ubds_pkg::ubds_pkt_t pkt,
    output var logic byte_strobe
);
    import ubds_pkg::*;
    initial begin
        pkt_valid = 1'b0;
        pkt = '0;
        byte_strobe = 1'b0;
    end
    // ========
    // One packet, then its handshake
    task automatic send(input ubds_tok_t t, input logic tg, er,
        input logic [9:0] n, output ubds_resp_t r);
        pkt_valid <= 1'b1;
        pkt <= '{t, tg, er, n};
        @(posedge mclk);
        pkt_valid <= 1'b0;
        pkt <= ubds_pkt_t'(~pkt);
        do begin
            @(posedge mclk);
        end while (resp_valid !== 1'b1);
        r = resp;
    endtask
    // ========
    // Byte moves
    task automatic strobes(input int n);
        repeat (n) begin
            byte_strobe <= 1'b1;
            @(posedge mclk);
            byte_strobe <= 1'b0;
            @(posedge mclk);
        end
    endtask
endmodule // ubds_host_model
`default_nettype wire

/* test/ubds_engine_bench.sv */
/*
 Self-checking bench of the descriptor status engine.
 Assumes the core files and ubds_host_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ubds_map.svh"
module ubds_engine_bench;
    import ubds_pkg::*;
    logic mclk, rstn = 1'b0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, rdata, v;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic pkt_valid, byte_strobe, resp_valid, fifo_push, irq;
    ubds_pkt_t pkt;
    ubds_resp_t resp, r;
    logic [9:0] buf_addr;
    int bad_count, total_checks, pushes, p;
    ubds_engine DUT (.mclk(mclk), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pkt_valid(pkt_valid), .pkt(pkt),
        .byte_strobe(byte_strobe), .resp_valid(resp_valid),
        .resp(resp), .buf_addr(buf_addr), .fifo_push(fifo_push),
        .irq(irq));
    ubds_host_model host (.mclk(mclk), .resp_valid(resp_valid),
        .resp(resp), .pkt_valid(pkt_valid), .pkt(pkt),
        .byte_strobe(byte_strobe));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) if (fifo_push === 1'b1) pushes++;
    // ========
    // Helpers
    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic rst;
        rstn <= 1'b0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s = 4'hF, input logic [1:0] e = 2'h0);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, e);
        @(posedge mclk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er = 2'h0);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        rready <= 1'b0;
        chk(v, e);
        chk(rresp, er);
        @(posedge mclk);
    endtask
    task automatic tx(input ubds_tok_t t, input logic tg, er,
        input logic [9:0] n, input ubds_hs_t h, input logic w);
        host.send(t, tg, er, n, r);
        chk(r, {h, w});
    endtask
    // ========
    // Scenarios
    task automatic t_regs;
        rc(`UBDS_STAT_OFS, 32'h0);
        rc(`UBDS_CNT_OFS, 32'h0);
        rc(`UBDS_ADDR_OFS, 32'h0);
        chk(irq, 1'b0);
        wr(8'h1C, 32'h0, 4'hF, 2'h2);
        rc(8'h1C, 32'h0, 2'h2);
        wr(`UBDS_STAT_OFS, 32'h80, 4'hE);
        rc(`UBDS_STAT_OFS, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_plain;
        p = pushes;
        wr(`UBDS_IRQ_MASK_OFS, 32'h3);
        wr(`UBDS_STAT_OFS, 32'h80);
        tx(UBDS_TOK_OUT, 1'b0, 1'b0, 10'h2A5, UBDS_HS_ACK, 1'b1);
        rc(`UBDS_STAT_OFS, 32'h02);
        rc(`UBDS_CNT_OFS, 32'hA5);
        chk(pushes - p, 1);
        chk(irq, 1'b1);
        wr(`UBDS_IRQ_STAT_OFS, 32'h1);
        chk(irq, 1'b0);
        wr(`UBDS_IRQ_MASK_OFS, 32'h0);
        wr(`UBDS_STAT_OFS, 32'h80);
        tx(UBDS_TOK_OUT, 1'b1, 1'b0, 10'h0, UBDS_HS_ACK, 1'b1);
        chk(irq, 1'b0);
        rc(`UBDS_IRQ_STAT_OFS, 32'h1);
        wr(`UBDS_IRQ_STAT_OFS, 32'h1);
        $display("test plain done");
    endtask
    task automatic t_toggle;
        p = pushes;
        for (int d = 0; d < 2; d++) begin
            wr(`UBDS_STAT_OFS, 32'h88 | (d << 6));
            tx(UBDS_TOK_OUT, !d[0], 1'b0, 10'h4, UBDS_HS_ACK, 1'b0);
            rc(`UBDS_STAT_OFS, 32'h88 | (d << 6));
            tx(UBDS_TOK_OUT, d[0], 1'b0, 10'h4, UBDS_HS_ACK, 1'b1);
            rc(`UBDS_STAT_OFS, 32'h08 | (d << 6));
        end
        chk(pushes - p, 2);
        $display("test toggle done");
    endtask
    task automatic t_error;
        wr(`UBDS_STAT_OFS, 32'h80);
        tx(UBDS_TOK_OUT, 1'b0, 1'b1, 10'h4, UBDS_HS_NAK, 1'b0);
        rc(`UBDS_STAT_OFS, 32'h80);
        tx(UBDS_TOK_OUT, 1'b0, 1'b0, 10'h4, UBDS_HS_ACK, 1'b1);
        tx(UBDS_TOK_OUT, 1'b0, 1'b0, 10'h4, UBDS_HS_NAK, 1'b0);
        $display("test error done");
    endtask
    task automatic t_stall;
        wr(`UBDS_IRQ_STAT_OFS, 32'h3);
        wr(`UBDS_STAT_OFS, 32'h84);
        tx(UBDS_TOK_IN, 1'b0, 1'b0, 10'h0, UBDS_HS_STALL, 1'b0);
        rc(`UBDS_EPCTL_OFS, 32'h1);
        rc(`UBDS_IRQ_STAT_OFS, 32'h2);
        tx(UBDS_TOK_OUT, 1'b0, 1'b0, 10'h0, UBDS_HS_STALL, 1'b0);
        rc(`UBDS_STAT_OFS, 32'h84);
        host.send(UBDS_TOK_SETUP, 1'b0, 1'b0, 10'h0, r);
        chk(r.hs, UBDS_HS_ACK);
        rc(`UBDS_STAT_OFS, 32'h0);
        wr(`UBDS_IRQ_STAT_OFS, 32'h2);
        $display("test stall done");
    endtask
    task automatic t_keep;
        p = pushes;
        wr(`UBDS_ADDR_OFS, 32'h20);
        wr(`UBDS_STAT_OFS, 32'hB0);
        host.strobes(3);
        chk(buf_addr, 10'h20);
        tx(UBDS_TOK_OUT, 1'b0, 1'b0, 10'h5, UBDS_HS_ACK, 1'b1);
        rc(`UBDS_STAT_OFS, 32'hB0);
        rc(`UBDS_IRQ_STAT_OFS, 32'h0);
        chk(pushes - p, 0);
        rc(`UBDS_FIFO_OFS, 32'h5);
        rst();
        wr(`UBDS_ADDR_OFS, 32'h20);
        wr(`UBDS_STAT_OFS, 32'hA0);
        host.strobes(3);
        chk(buf_addr, 10'h23);
        $display("test keep done");
    endtask
    // ========
    // Run control
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #40000;
        bad_count++;
        end_of_test();
    end
    initial begin
        rst();
        t_regs();
        t_plain();
        t_toggle();
        t_error();
        t_stall();
        t_keep();
        end_of_test();
    end
endmodule // ubds_engine_bench
`default_nettype wire
